// >>> src/rtcx_pkg.sv
package rtcx_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_PRIMARY   = 8'h00;
	localparam logic [7:0] OFF_SECONDARY = 8'h04;
	localparam logic [7:0] OFF_EVCTL     = 8'h08;
	localparam logic [7:0] OFF_TRIM      = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
	localparam logic [7:0] OFF_PRESC     = 8'h18;
	localparam logic [7:0] OFF_RET0      = 8'h20;
	localparam logic [7:0] OFF_RET3      = 8'h2C;

	// ---------------------------------------------------------------
	// Field layout
	// ---------------------------------------------------------------
	localparam int PRI_PSEL_LSB  = 0;
	localparam int PSEL_W        = 4;
	localparam int PRI_TCLR_BIT  = 4;
	localparam int SEC_PAIR_LSB  = 0;
	localparam int PAIR_W        = 2;
	localparam int TRIM_MAG_LSB  = 0;
	localparam int TRIM_MAG_W    = 7;
	localparam int TRIM_SIGN_BIT = 7;
	localparam int TAPS          = 8;
	localparam int TAP_BASE      = 2;
	localparam int PRESC_W       = 10;
	localparam int RET_WORDS     = 4;

	// ---------------------------------------------------------------
	// Timing and thresholds
	// ---------------------------------------------------------------
	localparam int TRIM_PERIOD_CYCLES = 8192;
	localparam int TRIM_CYCLE_PERIODS = 128;
	localparam logic [PSEL_W-1:0] PSEL_TRIM_MIN = 4'h1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic                              aw_have;
		logic [7:0]                        aw_addr;
		logic                              w_have;
		logic [31:0]                       w_data;
		logic [3:0]                        w_strb;
		logic                              bvalid;
		logic [1:0]                        bresp;
		logic                              rvalid;
		logic [31:0]                       rdata;
		logic [1:0]                        rresp;
		logic [PSEL_W-1:0]                 psel;
		logic                              tclr;
		logic [PAIR_W-1:0]                 pair_en;
		logic [TAPS-1:0]                   ev_en;
		logic [TRIM_MAG_W-1:0]             trim_mag;
		logic                              trim_sign;
		logic [TAPS-1:0]                   irq_stat;
		logic [TAPS-1:0]                   irq_mask;
		logic [PRESC_W-1:0]                presc;
		logic [TAPS-1:0]                   tap_ev;
		logic [RET_WORDS-1:0][31:0]        ret;
		logic                              tamper_q;
	} rtcx_state_t;

	localparam rtcx_state_t RTCX_STATE_RST = '0;

endpackage : rtcx_pkg

// >>> src/rtcx_sync.sv
`timescale 1ns/1ns
`default_nettype none

module rtcx_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} rtcx_sync_state_t;

	rtcx_sync_state_t r;
	rtcx_sync_state_t nxt;

	always_comb begin
		nxt.s1 = d;
		nxt.s2 = r.s1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end

	assign q = r.s2;

endmodule : rtcx_sync

`default_nettype wire

// >>> src/rtcx_trim.sv
`timescale 1ns/1ns
`default_nettype none

module rtcx_trim #(
	parameter int PERIOD_CYCLES = 8192,
	parameter int CYCLE_PERIODS = 128,
	parameter int MAG_W         = 7
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             allow,
	input  wire logic [MAG_W-1:0] mag,
	input  wire logic             sign,
	output logic                  step_hold,
	output logic                  step_skip
);

	localparam int PC_W = $clog2(PERIOD_CYCLES);
	localparam int IX_W = $clog2(CYCLE_PERIODS);
	localparam logic [PC_W-1:0] PC_LAST = PC_W'(PERIOD_CYCLES - 1);
	localparam logic [IX_W-1:0] IX_LAST = IX_W'(CYCLE_PERIODS - 1);

	typedef struct packed {
		logic [PC_W-1:0] pcnt;
		logic [IX_W-1:0] idx;
		logic            hold;
		logic            skip;
	} rtcx_trim_state_t;

	rtcx_trim_state_t r;
	rtcx_trim_state_t nxt;
	logic             apply;

	// ---------------------------------------------------------------
	// Correction sequencer
	// ---------------------------------------------------------------
	always_comb begin
		nxt   = r;
		apply = allow && (MAG_W'(r.idx) < mag);
		nxt.hold = 1'b0;
		nxt.skip = 1'b0;
		if (r.pcnt == PC_LAST) begin
			nxt.pcnt = '0;
			nxt.idx  = (r.idx == IX_LAST) ? '0 : IX_W'(r.idx + 1'b1);
			nxt.hold = apply && !sign;
			nxt.skip = apply && sign;
		end else begin
			nxt.pcnt = PC_W'(r.pcnt + 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end

	assign step_hold = r.hold;
	assign step_skip = r.skip;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	step_at_wrap_a: assert property ((step_hold || step_skip) |-> r.pcnt == '0)
		else $error("correction step away from period boundary");
	step_gap_a: assert property ((step_hold || step_skip) |=> !(step_hold || step_skip) [*8])
		else $error("two correction steps too close");
	step_allowed_a: assert property ((step_hold || step_skip) |-> $past(allow))
		else $error("correction step while not allowed");
	step_quota_a: assert property ((step_hold || step_skip) |-> MAG_W'($past(r.idx)) < $past(mag))
		else $error("correction step beyond magnitude");
	zero_mag_a: assert property ($past(mag) == '0 |-> !(step_hold || step_skip))
		else $error("correction step with zero magnitude");
	step_dir_a: assert property (step_hold |-> !$past(sign) && !step_skip)
		else $error("hold step with negative sign");

	hold_seen_c: cover property (step_hold);
	skip_seen_c: cover property (step_skip);

endmodule : rtcx_trim

`default_nettype wire

// >>> src/rtcx_top.sv
// Contract
// - Emit tap event on each rise of prescaler bit n+2 when enabled.
// - Tap n rate equals source clock divided by two to n+3.
// - Tap events ignore prescaler selection, except selection zero stops them all.
// - Apply rate correction only when prescaler selection exceeds one.
// - Each correction adds or skips one count, at most once per 8192 cycles.
// - Per 128 periods, apply exactly magnitude-field many corrections.
// - Sign chooses direction: positive adds counts, negative removes counts.
// - Corrections also shift the prescaler driving the tap events.
// - Four retention words, cleared only by reset or tamper with clear option.
// - Pair enable bit n enables retention words 2n and 2n+1.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module rtcx_top
	import rtcx_pkg::*;
#(
	parameter int PERIOD_CYCLES = rtcx_pkg::TRIM_PERIOD_CYCLES,
	parameter int CYCLE_PERIODS = rtcx_pkg::TRIM_CYCLE_PERIODS
) (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic                      tamper_in,
	output logic      [rtcx_pkg::TAPS-1:0] tap_event,
	output logic                           irq,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic [2:0]                s_axi_awprot,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output logic      [1:0]                s_axi_bresp,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic [2:0]                s_axi_arprot,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic      [31:0]               s_axi_rdata,
	output logic      [1:0]                s_axi_rresp
);

	rtcx_state_t       r;
	rtcx_state_t       nxt;
	logic              rst_n_s;
	logic              tamper_s;
	logic              step_hold;
	logic              step_skip;
	logic              trim_allow;
	logic              wr_fire;
	logic              tamper_rise;
	logic [PRESC_W-1:0] presc_new;

	// ---------------------------------------------------------------
	// Reset release and tamper pin synchronisers
	// ---------------------------------------------------------------
	rtcx_sync #(
		.WIDTH (1)
	) u_rst_sync (
		.clk    (clk),
		.arst_n (rstn),
		.d      (1'b1),
		.q      (rst_n_s)
	);

	rtcx_sync #(
		.WIDTH (1)
	) u_tamper_sync (
		.clk    (clk),
		.arst_n (rst_n_s),
		.d      (tamper_in),
		.q      (tamper_s)
	);

	// ---------------------------------------------------------------
	// Correction sequencer
	// ---------------------------------------------------------------
	assign trim_allow = (r.psel > PSEL_TRIM_MIN);

	rtcx_trim #(
		.PERIOD_CYCLES (PERIOD_CYCLES),
		.CYCLE_PERIODS (CYCLE_PERIODS),
		.MAG_W         (TRIM_MAG_W)
	) u_trim (
		.clk       (clk),
		.rst_n     (rst_n_s),
		.allow     (trim_allow),
		.mag       (r.trim_mag),
		.sign      (r.trim_sign),
		.step_hold (step_hold),
		.step_skip (step_skip)
	);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				v[8*b +: 8] = data[8*b +: 8];
			end
		end
		return v;
	endfunction : merge

	function automatic logic ret_hit(input logic [7:0] a);
		return (a >= OFF_RET0) && (a <= OFF_RET3) && (a[1:0] == 2'h0);
	endfunction : ret_hit

	function automatic logic mapped(input logic [7:0] a);
		logic m;
		m = ret_hit(a);
		case (a)
			OFF_PRIMARY, OFF_SECONDARY, OFF_EVCTL, OFF_TRIM,
			OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_PRESC: m = 1'b1;
			default: m = m;
		endcase
		return m;
	endfunction : mapped

	function automatic logic [31:0] read_word(input rtcx_state_t s, input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		case (a)
			OFF_PRIMARY: begin
				v[PRI_PSEL_LSB +: PSEL_W] = s.psel;
				v[PRI_TCLR_BIT]           = s.tclr;
			end
			OFF_SECONDARY: v[SEC_PAIR_LSB +: PAIR_W] = s.pair_en;
			OFF_EVCTL:     v[TAPS-1:0] = s.ev_en;
			OFF_TRIM: begin
				v[TRIM_MAG_LSB +: TRIM_MAG_W] = s.trim_mag;
				v[TRIM_SIGN_BIT]              = s.trim_sign;
			end
			OFF_IRQ_STAT:  v[TAPS-1:0] = s.irq_stat;
			OFF_IRQ_MASK:  v[TAPS-1:0] = s.irq_mask;
			OFF_PRESC:     v[PRESC_W-1:0] = s.presc;
			default: begin
				if (ret_hit(a)) begin
					v = s.ret[a[3:2]];
				end
			end
		endcase
		return v;
	endfunction : read_word

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	assign wr_fire     = r.aw_have && r.w_have && !r.bvalid;
	assign tamper_rise = tamper_s && !r.tamper_q;

	always_comb begin
		logic [TAPS-1:0] stat_clr;
		logic [TAPS-1:0] ev;
		stat_clr = '0;
		ev       = '0;
		nxt      = r;
		nxt.tamper_q = tamper_s;

		// Prescaler: hold adds a count, skip removes one
		if (step_hold) begin
			presc_new = r.presc;
		end else if (step_skip) begin
			presc_new = PRESC_W'(r.presc + 10'h002);
		end else begin
			presc_new = PRESC_W'(r.presc + 10'h001);
		end
		nxt.presc = presc_new;

		// Tap events on rising prescaler bits
		ev = r.ev_en & ~r.presc[TAP_BASE +: TAPS] & presc_new[TAP_BASE +: TAPS];
		if (r.psel == '0) begin
			ev = '0;
		end
		nxt.tap_ev = ev;

		// AXI address / data capture
		if (s_axi_awvalid && !r.aw_have && !r.bvalid) begin
			nxt.aw_have = 1'b1;
			nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r.w_have && !r.bvalid) begin
			nxt.w_have = 1'b1;
			nxt.w_data = s_axi_wdata;
			nxt.w_strb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			nxt.bvalid = 1'b0;
		end

		// Register write
		if (wr_fire) begin
			nxt.aw_have = 1'b0;
			nxt.w_have  = 1'b0;
			nxt.bvalid  = 1'b1;
			nxt.bresp   = mapped(r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			case (r.aw_addr)
				OFF_PRIMARY: begin
					logic [31:0] m;
					m = merge(read_word(r, OFF_PRIMARY), r.w_data, r.w_strb);
					nxt.psel = m[PRI_PSEL_LSB +: PSEL_W];
					nxt.tclr = m[PRI_TCLR_BIT];
				end
				OFF_SECONDARY: begin
					logic [31:0] m;
					m = merge(read_word(r, OFF_SECONDARY), r.w_data, r.w_strb);
					nxt.pair_en = m[SEC_PAIR_LSB +: PAIR_W];
				end
				OFF_EVCTL: begin
					logic [31:0] m;
					m = merge(read_word(r, OFF_EVCTL), r.w_data, r.w_strb);
					nxt.ev_en = m[TAPS-1:0];
				end
				OFF_TRIM: begin
					logic [31:0] m;
					m = merge(read_word(r, OFF_TRIM), r.w_data, r.w_strb);
					nxt.trim_mag  = m[TRIM_MAG_LSB +: TRIM_MAG_W];
					nxt.trim_sign = m[TRIM_SIGN_BIT];
				end
				OFF_IRQ_STAT: begin
					if (r.w_strb[0]) begin
						stat_clr = r.w_data[TAPS-1:0];
					end
				end
				OFF_IRQ_MASK: begin
					logic [31:0] m;
					m = merge(read_word(r, OFF_IRQ_MASK), r.w_data, r.w_strb);
					nxt.irq_mask = m[TAPS-1:0];
				end
				default: begin
					if (ret_hit(r.aw_addr) && r.pair_en[r.aw_addr[3]]) begin
						nxt.ret[r.aw_addr[3:2]] = merge(r.ret[r.aw_addr[3:2]],
							r.w_data, r.w_strb);
					end
				end
			endcase
		end

		// Sticky status: a new event wins over a clear
		nxt.irq_stat = (r.irq_stat & ~stat_clr) | ev;

		// Tamper clear of retention words
		if (tamper_rise && r.tclr) begin
			nxt.ret = '0;
		end

		// AXI read
		if (r.rvalid && s_axi_rready) begin
			nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !r.rvalid) begin
			nxt.rvalid = 1'b1;
			nxt.rdata  = read_word(r, s_axi_araddr);
			nxt.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			r <= RTCX_STATE_RST;
		end else begin
			r <= nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign tap_event     = r.tap_ev;
	assign irq           = |(r.irq_stat & r.irq_mask);
	assign s_axi_awready = !r.aw_have && !r.bvalid;
	assign s_axi_wready  = !r.w_have && !r.bvalid;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_s);

	tap_enable_a: assert property ((tap_event & ~$past(r.ev_en)) == '0)
		else $error("tap event on a disabled tap");
	tap_rise_a: assert property (r.ev_en[3] && r.psel != '0 && !r.presc[5] && presc_new[5]
		|=> tap_event[3])
		else $error("missed tap event on prescaler rise");
	tap_rate_a: assert property ((tap_event[0] && r.trim_mag == '0 && !step_hold && !step_skip)
		##1 (r.ev_en[0] && r.trim_mag == '0 && r.psel != '0) [*8] |-> tap_event[0])
		else $error("tap zero period is not eight cycles");
	tap_sel_zero_a: assert property ($past(r.psel) == '0 |-> tap_event == '0)
		else $error("tap event with zero prescaler selection");
	presc_hold_a: assert property (step_hold |=> r.presc == $past(r.presc))
		else $error("positive correction did not add a count");
	presc_skip_a: assert property (step_skip |=> r.presc == PRESC_W'($past(r.presc) + 10'h002))
		else $error("negative correction did not skip a count");
	presc_plain_a: assert property (!step_hold && !step_skip
		|=> r.presc == PRESC_W'($past(r.presc) + 10'h001))
		else $error("prescaler left plain count sequence");
	trim_gate_a: assert property (r.psel <= PSEL_TRIM_MIN [*2] |-> !step_hold && !step_skip)
		else $error("correction with low prescaler selection");
	ret_clear_a: assert property (tamper_rise && r.tclr |=> r.ret == '0)
		else $error("tamper did not clear retention words");
	ret_keep_a: assert property (!(tamper_rise && r.tclr) && !wr_fire |=> r.ret == $past(r.ret))
		else $error("retention word changed without cause");
	ret_locked_a: assert property (wr_fire && ret_hit(r.aw_addr) && !r.pair_en[r.aw_addr[3]]
		&& !(tamper_rise && r.tclr) |=> r.ret == $past(r.ret))
		else $error("write to a disabled retention pair landed");

	tap_seen_c: cover property (tap_event[0]);
	tap_step_c: cover property (step_skip ##[1:20] tap_event[0]);
	ret_clear_c: cover property (tamper_rise && r.tclr);
	irq_seen_c: cover property (irq);

endmodule : rtcx_top

`default_nettype wire

// >>> verification/rtcx_evsys_model.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// Event consumer: counts tap pulses per channel
// ---------------------------------------------------------------
module rtcx_evsys_model (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clr,
	input  wire logic [7:0]       tap_event,
	output logic      [7:0][15:0] counts
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			counts <= '0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				counts[i] <= clr ? 16'h0000 : counts[i] + {15'h0000, tap_event[i]};
			end
		end
	end
endmodule : rtcx_evsys_model

`default_nettype wire

// >>> verification/rtcx_top_tb.sv
`timescale 1ns/1ns
`default_nettype none

module rtcx_top_tb;
	import rtcx_pkg::*;

	localparam int PER = 16;
	localparam int CYC = 4;
	localparam int WIN = 1024;

	logic             clk           = 1'b0;
	logic             rstn          = 1'b0;
	logic             tamper_in     = 1'b0;
	logic [7:0]       tap_event;
	logic             irq;
	logic             s_axi_awvalid = 1'b0;
	logic             s_axi_awready;
	logic [7:0]       s_axi_awaddr  = 8'h00;
	logic             s_axi_wvalid  = 1'b0;
	logic             s_axi_wready;
	logic [31:0]      s_axi_wdata   = 32'h0;
	logic             s_axi_bvalid;
	logic             s_axi_bready  = 1'b0;
	logic [1:0]       s_axi_bresp;
	logic             s_axi_arvalid = 1'b0;
	logic             s_axi_arready;
	logic [7:0]       s_axi_araddr  = 8'h00;
	logic             s_axi_rvalid;
	logic             s_axi_rready  = 1'b0;
	logic [31:0]      s_axi_rdata;
	logic [1:0]       s_axi_rresp;
	logic             ev_clr        = 1'b0;
	logic [7:0][15:0] ev_counts;
	int               cyc           = 0;
	int               mismatches    = 0;
	int               comparisons   = 0;

	always #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	rtcx_top #(.PERIOD_CYCLES(PER), .CYCLE_PERIODS(CYC)) u_rtcx_top (
		.clk(clk), .rstn(rstn), .tamper_in(tamper_in), .tap_event(tap_event), .irq(irq),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
	);

	rtcx_evsys_model u_rtcx_evsys_model (
		.clk(clk), .rst_n(rstn), .clr(ev_clr), .tap_event(tap_event), .counts(ev_counts)
	);

	// ---------------------------------------------------------------
	// Comparison and bus tasks
	// ---------------------------------------------------------------
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask : check_bit

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int         n;
		logic       aw_go;
		logic       w_go;
		logic       b_go;
		logic [1:0] resp;
		n    = 0;
		resp = 2'h3;
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		// Handshakes are judged on settled values, ahead of the edge that takes them
		forever begin
			@(negedge clk);
			aw_go = s_axi_awvalid && s_axi_awready;
			w_go  = s_axi_wvalid && s_axi_wready;
			b_go  = (s_axi_bvalid === 1'b1);
			resp  = s_axi_bresp;
			@(posedge clk);
			if (aw_go) s_axi_awvalid <= 1'b0;
			if (w_go) s_axi_wvalid <= 1'b0;
			if (b_go) break;
			n++;
			if (n > 100) begin
				mismatches++;
				break;
			end
		end
		check_word({30'h0, resp}, {30'h0, er});
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
		output int c);
		int   n;
		logic ar_go;
		logic r_go;
		n = 0;
		c = 0;
		d = 32'h0;
		r = 2'h3;
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		forever begin
			@(negedge clk);
			ar_go = s_axi_arvalid && s_axi_arready;
			r_go  = (s_axi_rvalid === 1'b1);
			d     = s_axi_rdata;
			r     = s_axi_rresp;
			@(posedge clk);
			if (ar_go) begin
				s_axi_arvalid <= 1'b0;
				c = cyc;
			end
			if (r_go) break;
			n++;
			if (n > 100) begin
				mismatches++;
				break;
			end
		end
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] er = RESP_OKAY);
		logic [31:0] d;
		logic [1:0]  r;
		int          c;
		axi_read(a, d, r, c);
		check_word(d, exp);
		check_word({30'h0, r}, {30'h0, er});
	endtask : rd_chk

	task automatic pulse_tamper();
		@(posedge clk);
		tamper_in <= 1'b1;
		repeat (4) @(posedge clk);
		tamper_in <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulse_tamper

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic reset_values();
		for (int a = 0; a <= 'h2C; a += 4) begin
			if (a != 'h18) rd_chk(8'(a), 32'h0, (a == 'h1C) ? RESP_SLVERR : RESP_OKAY);
		end
		check_bit(irq, 1'b0);
		wr(8'h40, 32'h1234_5678, RESP_SLVERR);
		rd_chk(8'h40, 32'h0, RESP_SLVERR);
	endtask : reset_values

	task automatic tap_rates(input logic [3:0] psel, input logic [7:0] en);
		wr(OFF_TRIM, 32'h0);
		wr(OFF_PRIMARY, {28'h0, psel});
		wr(OFF_EVCTL, {24'h0, en});
		@(posedge clk);
		ev_clr <= 1'b1;
		@(posedge clk);
		ev_clr <= 1'b0;
		repeat (WIN + 1) @(posedge clk);
		for (int n = 0; n < 8; n++) begin
			check_word({16'h0, ev_counts[n]}, (psel != 4'h0 && en[n]) ? 32'(WIN >> (n + 3)) : 32'h0);
		end
	endtask : tap_rates

	task automatic trim_run(input logic [3:0] psel, input logic [7:0] trim, input int steps);
		logic [31:0] p1;
		logic [31:0] p2;
		logic [1:0]  r;
		int          c1;
		int          c2;
		wr(OFF_TRIM, {24'h0, trim});
		wr(OFF_PRIMARY, {28'h0, psel});
		axi_read(OFF_PRESC, p1, r, c1);
		repeat (WIN - 3) @(posedge clk);
		axi_read(OFF_PRESC, p2, r, c2);
		check_word(32'(c2 - c1), 32'(WIN));
		check_word((p2 - p1) & 32'h3FF, 32'(WIN + steps) & 32'h3FF);
	endtask : trim_run

	task automatic irq_flow();
		// Earlier scenarios leave sticky status behind
		wr(OFF_EVCTL, 32'h0);
		wr(OFF_IRQ_STAT, 32'hFF);
		rd_chk(OFF_IRQ_STAT, 32'h0);
		wr(OFF_PRIMARY, 32'h1);
		wr(OFF_IRQ_MASK, 32'h1);
		wr(OFF_EVCTL, 32'h3);
		repeat (20) @(posedge clk);
		check_bit(irq, 1'b1);
		wr(OFF_EVCTL, 32'h0);
		rd_chk(OFF_IRQ_STAT, 32'h3);
		wr(OFF_IRQ_STAT, 32'h1);
		check_bit(irq, 1'b0);
		rd_chk(OFF_IRQ_STAT, 32'h2);
		wr(OFF_IRQ_STAT, 32'h2);
		rd_chk(OFF_IRQ_STAT, 32'h0);
	endtask : irq_flow

	task automatic retention();
		wr(OFF_SECONDARY, 32'h0);
		wr(OFF_RET0, 32'hA5A5_0001);
		rd_chk(OFF_RET0, 32'h0);
		wr(OFF_SECONDARY, 32'h1);
		wr(OFF_RET0, 32'h1111_2222);
		wr(OFF_RET0 + 8'h04, 32'h3333_4444);
		wr(OFF_RET0 + 8'h08, 32'h5555_6666);
		rd_chk(OFF_RET0, 32'h1111_2222);
		rd_chk(OFF_RET0 + 8'h04, 32'h3333_4444);
		rd_chk(OFF_RET0 + 8'h08, 32'h0);
		wr(OFF_SECONDARY, 32'h2);
		wr(OFF_RET3, 32'h7777_8888);
		rd_chk(OFF_RET3, 32'h7777_8888);
		wr(OFF_PRIMARY, 32'h1);
		pulse_tamper();
		rd_chk(OFF_RET0, 32'h1111_2222);
		wr(OFF_PRIMARY, 32'h11);
		pulse_tamper();
		rd_chk(OFF_RET0, 32'h0);
		rd_chk(OFF_RET3, 32'h0);
	endtask : retention

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		reset_values();
		tap_rates(4'h1, 8'hFF);
		tap_rates(4'h9, 8'hA5);
		tap_rates(4'h0, 8'hFF);
		trim_run(4'h2, 8'h02, -32);
		trim_run(4'h2, 8'h82, 32);
		trim_run(4'h1, 8'h02, 0);
		trim_run(4'h2, 8'h00, 0);
		trim_run(4'h2, 8'h7F, -64);
		irq_flow();
		retention();
		print_verdict();
	end

	initial begin
		#(40 * 30000);
		mismatches++;
		print_verdict();
	end
endmodule : rtcx_top_tb

`default_nettype wire
